// >>> common/lsac_map.svh
`ifndef LSAC_MAP_SVH
`define LSAC_MAP_SVH

// ==========================================================
// register offsets
`define LSAC_OFS_CMD      8'h00
`define LSAC_OFS_RANGE    8'h01
`define LSAC_OFS_RES_LO   8'h04
`define LSAC_OFS_RES_HI   8'h05
`define LSAC_OFS_TMR_LO   8'h06
`define LSAC_OFS_TMR_HI   8'h07

// ==========================================================
// field positions and reset values
`define LSAC_CMD_ENABLE   7
`define LSAC_CMD_PDOWN    6
`define LSAC_CMD_EXTTIM   5
`define LSAC_CMD_WMASK    8'hEF
`define LSAC_RNG_WMASK    8'h0C
`define LSAC_CMD_RESET    8'h00
`define LSAC_RNG_RESET    8'h00
`define LSAC_SYNC_BIT     7
`define LSAC_SLAVE_HI     6'h22
`define LSAC_PD_LIGHT     2'h2

// ==========================================================
// conversion cycle counts and result limits
`define LSAC_CYC_12       17'h01000
`define LSAC_CYC_8        17'h00100
`define LSAC_CYC_4        17'h00010
`define LSAC_MAX_16       16'h7FFF
`define LSAC_MAX_12       16'h07FF
`define LSAC_MAX_8        16'h007F
`define LSAC_MAX_4        16'h0007

`endif

// >>> common/lsac_pkg.sv
package lsac_pkg;
    typedef enum logic [1:0] {
        LSAC_EXT_WAIT = 2'b00,
        LSAC_EXT_ARR1 = 2'b01,
        LSAC_EXT_ARR2 = 2'b10
    } lsac_ext_e;

    typedef logic [16:0] lsac_cyc_t;
endpackage

// >>> rtl/lsac_core.sv
`timescale 1ns/1ns
`include "lsac_map.svh"
module lsac_core #(
    parameter logic [16:0] CYC_16 = 17'h10000
) (
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       reset_n_i,
    // pins
    input  wire logic       address_select_pin_i,
    input  wire logic       light_pulse_i,
    // register access from the serial front end
    input  wire logic [6:0] slave_addr_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] wdata_i,
    output logic            addr_match_o,
    output logic [7:0]      rdata_o,
    output logic            rvalid_o,
    // analog control
    output logic            core_reset_o,
    output logic            converter_power_down_o,
    output logic [1:0]      full_scale_span_o,
    output logic            osc_half_speed_o,
    output logic            conv_done_o
);
    // ==========================================================
    // pin synchronisation
    logic [1:0] pins_s;
    logic       pulse_d_r;

    lsac_sync #(
        .WIDTH (2)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .async_i   ({light_pulse_i, address_select_pin_i}),
        .sync_o    (pins_s)
    );

    wire logic addr_sel_s = pins_s[0];
    wire logic pulse_rise = pins_s[1] & ~pulse_d_r;

    // ==========================================================
    // address decode
    logic [7:0] cmd_r;
    logic [7:0] rng_r;

    assign addr_match_o = (slave_addr_i == {`LSAC_SLAVE_HI, addr_sel_s});

    wire logic wr_ok    = wr_i & addr_match_o;
    wire logic rd_ok    = rd_i & addr_match_o;
    wire logic reg_page = (reg_addr_i[7:6] == 2'b00);
    wire logic wr_cmd   = wr_ok & reg_page & (reg_addr_i == `LSAC_OFS_CMD);
    wire logic wr_rng   = wr_ok & reg_page & (reg_addr_i == `LSAC_OFS_RANGE);
    wire logic ext_mode = cmd_r[`LSAC_CMD_EXTTIM];
    wire logic sync_cmd = wr_ok & reg_addr_i[`LSAC_SYNC_BIT] & ext_mode;

    // ==========================================================
    // command and range registers
    // hold until rewritten
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            cmd_r <= `LSAC_CMD_RESET;
            rng_r <= `LSAC_RNG_RESET;
        end else begin
            if (wr_cmd) begin
                cmd_r <= wdata_i & `LSAC_CMD_WMASK;
            end
            if (wr_rng) begin
                rng_r <= wdata_i & `LSAC_RNG_WMASK;
            end
        end
    end

    // ==========================================================
    // mode decode
    wire logic [1:0] pd_sel = cmd_r[3:2];
    wire logic [1:0] width  = cmd_r[1:0];

    wire logic core_rst = ~cmd_r[`LSAC_CMD_ENABLE] | cmd_r[`LSAC_CMD_PDOWN] | ~pd_sel[1];
    // no-operation code freezes the converter
    wire logic core_run = ~core_rst & (pd_sel == `LSAC_PD_LIGHT);

    assign core_reset_o           = core_rst;
    assign converter_power_down_o = cmd_r[`LSAC_CMD_PDOWN];
    // range select to analog front end
    assign full_scale_span_o      = rng_r[3:2];
    assign osc_half_speed_o       = ~rng_r[3];

    wire lsac_pkg::lsac_cyc_t cyc_limit =
        (width == 2'h0) ? CYC_16 :
        (width == 2'h1) ? `LSAC_CYC_12 :
        (width == 2'h2) ? `LSAC_CYC_8 : `LSAC_CYC_4;
    wire logic [15:0] res_max =
        (width == 2'h0) ? `LSAC_MAX_16 :
        (width == 2'h1) ? `LSAC_MAX_12 :
        (width == 2'h2) ? `LSAC_MAX_8 : `LSAC_MAX_4;

    // ==========================================================
    // integration sequencing
    lsac_pkg::lsac_cyc_t   cyc_r;
    lsac_pkg::lsac_cyc_t   cyc_nxt;
    lsac_pkg::lsac_ext_e   ext_r;
    lsac_pkg::lsac_ext_e   ext_nxt;
    logic [15:0]           tmr_r;
    logic [15:0]           acc_r;
    logic [15:0]           res_r;
    logic [15:0]           tmr_pub_r;
    logic                  done_r;

    wire logic int_end   = core_run & ~ext_mode & (cyc_r == cyc_limit - 17'h00001);
    wire logic ext_end   = core_run & sync_cmd & (ext_r == lsac_pkg::LSAC_EXT_ARR2);
    wire logic integ_end = int_end | ext_end;
    wire logic integ_on  = core_run & (~ext_mode | (ext_r != lsac_pkg::LSAC_EXT_WAIT));
    wire logic [15:0] acc_sat = (acc_r > res_max) ? res_max : acc_r;

    assign cyc_nxt = (int_end | ext_mode) ? 17'h00000 : cyc_r + 17'h00001;

    always_comb begin
        ext_nxt = ext_r;
        if (sync_cmd) begin
            unique case (ext_r)
                lsac_pkg::LSAC_EXT_WAIT: ext_nxt = lsac_pkg::LSAC_EXT_ARR1;
                lsac_pkg::LSAC_EXT_ARR1: ext_nxt = lsac_pkg::LSAC_EXT_ARR2;
                lsac_pkg::LSAC_EXT_ARR2: ext_nxt = lsac_pkg::LSAC_EXT_ARR1;
                default:                 ext_nxt = lsac_pkg::LSAC_EXT_WAIT;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            pulse_d_r <= 1'b0;
        end else begin
            pulse_d_r <= pins_s[1];
        end
    end

    // counters cleared while core in reset
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i || core_rst || !ext_mode) begin
            ext_r <= lsac_pkg::LSAC_EXT_WAIT;
        end else if (core_run) begin
            ext_r <= ext_nxt;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i || core_rst) begin
            cyc_r <= 17'h00000;
        end else if (core_run) begin
            cyc_r <= cyc_nxt;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i || core_rst) begin
            tmr_r <= 16'h0000;
            acc_r <= 16'h0000;
        end else if (integ_end || (sync_cmd && ext_r == lsac_pkg::LSAC_EXT_WAIT)) begin
            tmr_r <= 16'h0000;
            acc_r <= 16'h0000;
        end else if (integ_on) begin
            // saturate: tmr_r holds at FFFF, yet tmr_r + 1 at publish reads an overlong external window as 0000
            tmr_r <= (tmr_r == 16'hFFFF) ? tmr_r : tmr_r + 16'h0001;
            acc_r <= (pulse_rise && acc_r != 16'hFFFF) ? acc_r + 16'h0001 : acc_r;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            res_r     <= 16'h0000;
            tmr_pub_r <= 16'h0000;
            done_r    <= 1'b0;
        end else begin
            done_r <= integ_end;
            if (integ_end) begin
                res_r     <= acc_sat;
                tmr_pub_r <= ext_mode ? tmr_r + 16'h0001 : 16'h0000;
            end
        end
    end

    assign conv_done_o = done_r;

    // ==========================================================
    // read path
    // read data select
    wire logic [7:0] rd_mux =
        (reg_addr_i == `LSAC_OFS_CMD)    ? cmd_r :
        (reg_addr_i == `LSAC_OFS_RANGE)  ? rng_r :
        (reg_addr_i == `LSAC_OFS_RES_LO) ? res_r[7:0] :
        (reg_addr_i == `LSAC_OFS_RES_HI) ? res_r[15:8] :
        (reg_addr_i == `LSAC_OFS_TMR_LO) ? tmr_pub_r[7:0] :
        (reg_addr_i == `LSAC_OFS_TMR_HI) ? tmr_pub_r[15:8] : 8'h00;

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            rdata_o  <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_ok;
            if (rd_ok) begin
                rdata_o <= rd_mux;
            end
        end
    end

    // ==========================================================
    // checks
    // cycles since the last 16-cycle end, parked at 1F once the run is broken
    logic [4:0] short_run_r;
    wire logic  short_steady = core_run & ~ext_mode & (width == 2'h3) & ~wr_cmd;

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            short_run_r <= 5'h1F;
        end else if (int_end) begin
            short_run_r <= 5'h00;
        end else if (!short_steady) begin
            short_run_r <= 5'h1F;
        end else if (short_run_r != 5'h1F) begin
            short_run_r <= short_run_r + 5'h01;
        end
    end

    int_reset_hold_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        !cmd_r[`LSAC_CMD_ENABLE] |=> (cyc_r == 17'h00000) && (tmr_r == 16'h0000))
        else $error("counters not held while disabled");
    pdown_out_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        wr_cmd && wdata_i[6] |=> converter_power_down_o && core_reset_o)
        else $error("power-down not applied");
    int_period_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        int_end && $stable(cmd_r) |-> cyc_r == cyc_limit - 17'h00001)
        else $error("internal period wrong");
    short_period_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        short_run_r == 5'h0F && core_run && !ext_mode && width == 2'h3 |-> int_end)
        else $error("16-cycle period missed");
    res_width_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        done_r |-> res_r <= $past(res_max))
        else $error("result exceeds n-1 bits");
    noop_freeze_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        cmd_r[7:6] == 2'b10 && pd_sel == 2'h3 && $past(pd_sel) == 2'h3 |-> $stable(cyc_r))
        else $error("no-op mode advanced");
    int_timer_zero_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        done_r && !ext_mode && $past(!ext_mode) |-> tmr_pub_r == 16'h0000)
        else $error("internal timer not zero");
    ext_third_sync_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        integ_end && ext_mode |=> done_r && ext_r == lsac_pkg::LSAC_EXT_ARR1)
        else $error("external measurement not restarted");
    hold_regs_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        !wr_cmd && !wr_rng |=> $stable(cmd_r) && $stable(rng_r))
        else $error("control changed without write");
    readback_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        rd_ok && reg_addr_i == `LSAC_OFS_RANGE && !wr_rng |=> rvalid_o && rdata_o == rng_r)
        else $error("range readback wrong");
    slave_addr_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        slave_addr_i[6:1] != 6'h22 |-> !addr_match_o)
        else $error("foreign address matched");
    no_update_rst_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        core_rst && $past(core_rst) |-> $stable(res_r))
        else $error("result changed in reset");

    ext_meas_c: cover property (@(posedge ref_clk_i) ext_end);
    int_meas_c: cover property (@(posedge ref_clk_i) int_end && width == 2'h3);
    read_res_c: cover property (@(posedge ref_clk_i) rd_ok && reg_addr_i == `LSAC_OFS_RES_HI);
    sync_wait_c: cover property (@(posedge ref_clk_i) sync_cmd && ext_r == lsac_pkg::LSAC_EXT_WAIT);
endmodule // lsac_core

// >>> rtl/lsac_sync.sv
`timescale 1ns/1ns
module lsac_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             reset_n_i,
    // data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            meta_r <= '0;
            sync_o <= '0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule // lsac_sync

// >>> sim/light_sensor_adc_control_tb_top.sv
`timescale 1ns/1ns
module light_sensor_adc_control_tb_top;
    // ==========================================================
    // signals
    localparam logic [16:0] CYC_SIM = 17'h00040;
    logic       ref_clk_i, reset_n_i, address_select_pin_i, light_pulse_i, light_on;
    logic       wr, rd, rvalid, core_reset, pdown, half_speed, conv_done;
    logic [6:0] slave_addr;
    logic [7:0] reg_addr, wdata, rdata;
    logic [1:0] span;
    logic [7:0] cmd_list [4] = '{8'h8F, 8'h0B, 8'hCB, 8'h83};
    int         errors = 0;
    int         check_count = 0;
    int         cycles = 0;

    lsac_core #(.CYC_16(CYC_SIM)) lsac_core_inst (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .address_select_pin_i(address_select_pin_i), .light_pulse_i(light_pulse_i),
        .slave_addr_i(slave_addr), .reg_addr_i(reg_addr), .wr_i(wr), .rd_i(rd),
        .wdata_i(wdata), .addr_match_o(), .rdata_o(rdata), .rvalid_o(rvalid),
        .core_reset_o(core_reset), .converter_power_down_o(pdown),
        .full_scale_span_o(span), .osc_half_speed_o(half_speed), .conv_done_o(conv_done)
    );

    lsac_host_model lsac_host_model_inst (
        .ref_clk_i(ref_clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .slave_addr_o(slave_addr),
        .reg_addr_o(reg_addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd)
    );

    // ==========================================================
    // clock, light source, hang guard
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    // one light count every two cycles
    always @(negedge ref_clk_i) light_pulse_i <= light_on & ~light_pulse_i;

    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end

    // ==========================================================
    // helpers
    task automatic print_verdict();
        if (errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input int tol,
                       input string what);
        check_count++;
        if (^got === 1'bx || got > exp + tol || got + tol < exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [15:0] period(input logic [1:0] w);
        return (w == 2'h0) ? CYC_SIM[15:0] : 16'h0010 << (4 * (3 - w));
    endfunction

    // saturation of an unsigned (n - 1) bit count
    function automatic logic [15:0] cap(input logic [1:0] w);
        return (16'h0001 << (3 + 4 * (3 - w))) - 16'h0001;
    endfunction

    task automatic put_reg(input logic [7:0] a, input logic [7:0] d);
        lsac_host_model_inst.wr_reg(a, d);
    endtask

    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        lsac_host_model_inst.rd_reg(a, v[7:0]);
        lsac_host_model_inst.rd_reg(a + 8'h01, v[15:8]);
    endtask

    task automatic wait_done(output int n);
        n = 0;
        while (conv_done !== 1'b1 && n < 9000) begin
            @(negedge ref_clk_i);
            n++;
        end
    endtask

    task automatic quiet(input int len);
        int hits;
        hits = 0;
        repeat (len) begin
            @(negedge ref_clk_i);
            if (conv_done === 1'b1) hits++;
        end
        chk(16'(hits), 16'h0000, 0, "unexpected result");
    endtask

    // ==========================================================
    // main sequence
    initial begin
        logic [15:0] v;
        logic [7:0]  c;
        logic [7:0]  g;
        int          n;
        int          t1;
        int          t2;
        {reset_n_i, address_select_pin_i, light_pulse_i, light_on} = 4'h0;
        n = $urandom(32'h07512514);
        repeat (8) @(posedge ref_clk_i);
        @(negedge ref_clk_i) reset_n_i = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        chk(16'(core_reset), 16'h0001, 0, "core held");
        for (int a = 0; a < 8; a += 2) begin
            rd16(8'(a), v);
            chk(v, 16'h0000, 0, "reset value");
        end
        for (int i = 0; i < 16; i++) begin
            c = (i < 4) ? cmd_list[i] : 8'($urandom);
            g = (i < 4) ? 8'(i * 4) : 8'($urandom);
            put_reg(8'h00, c);
            put_reg(8'h01, g);
            put_reg(8'h04, ~c);
            rd16(8'h00, v);
            chk(v, {g & 8'h0C, c & 8'hEF}, 0, "readback");
            chk(16'({span, half_speed}), 16'({g[3:2], ~g[3]}), 0, "range");
            chk(16'({pdown, core_reset}), 16'({c[6], ~c[7] | c[6] | ~c[3]}), 0, "ctl");
        end
        lsac_host_model_inst.target = 7'h45;
        put_reg(8'h00, 8'h8B);
        lsac_host_model_inst.target = 7'h44;
        rd16(8'h00, v);
        chk(16'(v[7:0]), 16'(c & 8'hEF), 0, "foreign address");
        address_select_pin_i = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        lsac_host_model_inst.target = 7'h45;
        light_on = 1'b1;
        for (int w = 3; w >= 0; w--) begin
            put_reg(8'h00, 8'h00);
            put_reg(8'h00, 8'h88 | 8'(w));
            wait_done(n);
            @(negedge ref_clk_i);
            wait_done(n);
            chk(16'(n + 1), period(2'(w)), 0, "period");
            rd16(8'h04, v);
            if (w != 0) chk(v, cap(2'(w)), 0, "saturated count");
            rd16(8'h06, v);
            chk(v, 16'h0000, 0, "internal timer");
        end
        light_on = 1'b0;
        put_reg(8'h00, 8'h00);
        put_reg(8'h00, 8'h8B);
        wait_done(n);
        @(negedge ref_clk_i);
        wait_done(n);
        rd16(8'h04, v);
        chk(v, 16'h0000, 0, "dark count");
        light_on = 1'b1;
        wait_done(n);
        @(negedge ref_clk_i);
        wait_done(n);
        light_on = 1'b0;
        foreach (cmd_list[i]) begin
            put_reg(8'h00, cmd_list[i]);
            quiet(40);
            rd16(8'h04, v);
            chk(v, 16'h0007, 0, "held result");
        end
        put_reg(8'h00, 8'hAB);
        lsac_host_model_inst.sync_cmd();
        t1 = cycles;
        for (int k = 0; k < 2; k++) begin
            g = 8'(10 + $urandom % 40);
            quiet(g);
            lsac_host_model_inst.sync_cmd();
            quiet(g);
            lsac_host_model_inst.sync_cmd();
            t2 = cycles;
            wait_done(n);
            chk(16'(n), 16'h0001, 1, "sync to result");
            rd16(8'h06, v);
            chk(v, 16'(t2 - t1), 1, "window timer");
            rd16(8'h04, v);
            chk(v, 16'h0000, 0, "ext count");
            t1 = t2;
        end
        print_verdict();
    end
endmodule // light_sensor_adc_control_tb_top

// >>> sim/lsac_host_model.sv
`timescale 1ns/1ns
module lsac_host_model (
    // clock
    input  wire logic       ref_clk_i,
    // answers from the block
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    // requests to the block
    output logic      [6:0] slave_addr_o,
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o
);
    // ==========================================================
    // bus driving
    // addressed device
    logic [6:0] target = 7'h44;

    initial begin
        {slave_addr_o, reg_addr_o, wdata_o, wr_o, rd_o} = '0;
    end

    // released address and data lines show inverted leftovers and strobes drop, so stale values cannot pass
    task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(negedge ref_clk_i);
        {slave_addr_o, reg_addr_o, wdata_o, wr_o, rd_o} = {target, a, d, w, ~w};
        @(negedge ref_clk_i);
        {slave_addr_o, reg_addr_o, wdata_o, wr_o, rd_o} = {~target, ~a, ~d, 2'b00};
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        put(a, d, 1'b1);
    endtask

    // answer must stand in the cycle after the request edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        put(a, 8'hA5, 1'b0);
        d = (rvalid_i === 1'b1) ? rdata_i : 8'hXX;
    endtask

    task automatic sync_cmd();
        put(8'h80, 8'h01, 1'b1);
    endtask
endmodule // lsac_host_model
